/* File: rtl/uart_consts.svh */
// register offsets, field positions, reset values and timing counts of the serial port
// assumes inclusion by bare name from the port module and the testbench
// Notes on behaviour
// - mode 001: eight data bits, no parity
// - mode 011: seven data bits plus parity
// - mode 111: eight data bits plus parity
// - mode 101: eight data bits plus wake-up bit
// - even parity is xor of data; odd inverts
// - wake-up mode keeps only frames with ninth bit set
// - each data write with byte 0 strobe pushes into 16x9 queue
// - queue on: full at 16, extra write dropped
// - queue off: full at one, write replaces it
// - half free: at most 8, or empty if off
// - flush write empties queue; flush after enable change
// - idle load at once, start on next tick
// - reload at stop, next start follows stop
// - empty queue at stop empties shifter flag
// - echo routes the registered transmit pin into receiver input
// - both directions share mode and baud rate
// - oversample tick is clock over divisor, run only
// - run low freezes transmitter and receiver
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH
`define OFF_CTRL   8'h00
`define OFF_BAUD   8'h04
`define OFF_TXW    8'h08
`define OFF_FLUSH  8'h0c
`define OFF_STAT   8'h10
`define OFF_RXD    8'h14
`define CTL_ODD    3
`define CTL_RUN    4
`define CTL_QEN    5
`define CTL_ECHO   6
`define CTRL_RST   7'h01
`define BAUD_RST   16'h0001
`define MODE_8N    3'h1
`define MODE_7P    3'h3
`define MODE_9N    3'h4
`define MODE_WAKE  3'h5
`define MODE_8P    3'h7
`define TXQ_DEPTH  16
`define TXQ_HALF   8
`define OS_LAST    4'hf
`define OS_MID     4'h7
`define BIT_LAST8  4'h7
`define BIT_LAST9  4'h8
`define RESP_OK    2'h0
`define RESP_ERR   2'h2
`endif

/* File: rtl/uart_pkg.sv */
// state types of the serial port
// assumes uart_consts.svh beside it
package uart_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_LOADED = 5'h02, TX_START = 5'h04, TX_DATA = 5'h08, TX_STOP = 5'h10
  } tx_state_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8
  } rx_state_t;
endpackage

/* File: rtl/uart_port.sv */
// serial port: axi4-lite registers, transmit queue, framer, simple receiver
// assumes one clock, synchronous reset, rxd_i from outside the clock domain
`timescale 1ns/1ps
`include "uart_consts.svh"
module uart_port
  import uart_pkg::*;
#(
  parameter int DEPTH = `TXQ_DEPTH,
  parameter int HALF  = `TXQ_HALF
) (
  // clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // serial pins
  input  wire logic        rxd_i,
  output logic             txd_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // decoding used by both bus directions
  function automatic logic hit(input logic [7:0] a);
    hit = (a == `OFF_CTRL) || (a == `OFF_BAUD) || (a == `OFF_TXW) ||
          (a == `OFF_FLUSH) || (a == `OFF_STAT) || (a == `OFF_RXD);
  endfunction

  // nine-bit frame lengths
  function automatic logic len9(input logic [2:0] m);
    len9 = (m == `MODE_9N) || (m == `MODE_8P) || (m == `MODE_WAKE);
  endfunction

  // shifter image of one character, lsb goes out first
  function automatic logic [8:0] build(input logic [2:0] m, input logic odd,
                                       input logic [8:0] d);
    case (m)
      `MODE_7P: build = {1'b1, ^d[6:0] ^ odd, d[6:0]};
      `MODE_8P: build = {^d[7:0] ^ odd, d[7:0]};
      `MODE_8N: build = {1'b1, d[7:0]};
      default:  build = d;
    endcase
  endfunction

  logic [6:0]       ctrl_q, ctrl_d;
  logic [15:0]      baud_q, baud_d, div_q, div_d;
  logic             bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]       bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]      rdata_q, rdata_d;
  logic [8:0]       mem_q [DEPTH];
  logic [8:0]       mem_d [DEPTH];
  logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  tx_state_t        tst_q, tst_d;
  rx_state_t        rst_q, rst_d;
  logic [3:0]       tcnt_q, tcnt_d, tbit_q, tbit_d, rcnt_q, rcnt_d, rbit_q, rbit_d;
  logic [8:0]       sh_q, sh_d, rsh_q, rsh_d;
  logic             shf_q, shf_d, len9_q, len9_d, txd_q, txd_d;
  logic             s1_q, s2_q, rxf_q, rxf_d;
  logic [9:0]       rxb_q, rxb_d;
  logic             wr_go, rd_go, push, pop, flush, rx_clr, full, half_free, tick;
  logic             run, qen, q_ne, bit_end, last_bit, stop_begin, rin, rx_done, rx_keep;
  logic [2:0]       mode;
  logic [31:0]      rd_mux;

  assign mode = ctrl_q[2:0];
  assign run  = ctrl_q[`CTL_RUN];
  assign qen  = ctrl_q[`CTL_QEN];

  // bus handshakes; one write and one read in flight, ce low refuses
  assign wr_go  = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_q & ce_i;
  assign rd_go  = s_axi_arvalid_i & ~rvalid_q & ce_i;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o  = wr_go;
  assign s_axi_arready_o = rd_go;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rresp_o   = rresp_q;
  assign s_axi_rdata_o   = rdata_q;
  assign txd_o           = txd_q;

  // queue strobes and flags
  assign push  = wr_go & (s_axi_awaddr_i == `OFF_TXW) & s_axi_wstrb_i[0];
  assign flush = wr_go & (s_axi_awaddr_i == `OFF_FLUSH);
  assign rx_clr = rd_go & (s_axi_araddr_i == `OFF_RXD);
  assign q_ne  = (cnt_q != '0);
  assign full  = qen ? (cnt_q == CW'(DEPTH)) : q_ne;
  assign half_free = qen ? (cnt_q <= CW'(HALF)) : ~q_ne;

  // read data selection
  always_comb begin
    case (s_axi_araddr_i)
      `OFF_CTRL: rd_mux = {25'h0, ctrl_q};
      `OFF_BAUD: rd_mux = {16'h0, baud_q};
      `OFF_STAT: rd_mux = {28'h0, rxf_q, ~shf_q, half_free, full};
      `OFF_RXD:  rd_mux = {22'h0, rxb_q};
      default:   rd_mux = 32'h0;
    endcase
  end

  // register writes and bus answers, one cycle after the handshake
  always_comb begin
    ctrl_d   = ctrl_q;
    baud_d   = baud_q;
    bvalid_d = bvalid_q & ~s_axi_bready_i;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q & ~s_axi_rready_i;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d  = hit(s_axi_awaddr_i) ? `RESP_OK : `RESP_ERR;
      if (s_axi_awaddr_i == `OFF_CTRL && s_axi_wstrb_i[0]) begin
        ctrl_d = s_axi_wdata_i[6:0];
      end
      if (s_axi_awaddr_i == `OFF_BAUD) begin
        if (s_axi_wstrb_i[0]) baud_d[7:0] = s_axi_wdata_i[7:0];
        if (s_axi_wstrb_i[1]) baud_d[15:8] = s_axi_wdata_i[15:8];
      end
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_mux;
      rresp_d  = hit(s_axi_araddr_i) ? `RESP_OK : `RESP_ERR;
    end
  end

  // 16x oversample tick; a divisor of zero acts as one
  always_comb begin
    tick  = run & ((baud_q <= 16'h0001) || (div_q == baud_q - 16'h0001));
    div_d = run ? (tick ? 16'h0 : div_q + 16'h0001) : div_q;
  end

  // transmit queue; pointers wrap, so DEPTH must be a power of two
  always_comb begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    mem_d = mem_q;
    if (pop) begin
      rp_d  = rp_q + PW'(1);
      cnt_d = cnt_d - CW'(1);
    end
    if (push) begin
      if (!qen && full && !pop) begin
        mem_d[rp_q] = s_axi_wdata_i[8:0];
      end else if (!full || pop) begin
        mem_d[wp_q] = s_axi_wdata_i[8:0];
        wp_d  = wp_q + PW'(1);
        cnt_d = cnt_d + CW'(1);
      end
    end
    if (flush) begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end
  end

  // transmit framer
  assign bit_end    = tick & (tcnt_q == `OS_LAST);
  assign last_bit   = (tbit_q == (len9_q ? `BIT_LAST9 : `BIT_LAST8));
  assign stop_begin = (tst_q == TX_DATA) & bit_end & last_bit;
  assign pop = run & q_ne & (stop_begin |
               (((tst_q == TX_IDLE) | (tst_q == TX_STOP)) & ~shf_q));

  always_comb begin
    tst_d  = tst_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    sh_d   = sh_q;
    shf_d  = shf_q;
    len9_d = len9_q;
    if (run) begin
      if (tick) tcnt_d = tcnt_q + 4'h1;
      case (tst_q)
        TX_IDLE:   if (pop) tst_d = TX_LOADED;
        TX_LOADED: if (tick) begin
          tst_d  = TX_START;
          tcnt_d = 4'h0;
        end
        TX_START:  if (bit_end) begin
          tst_d  = TX_DATA;
          tbit_d = 4'h0;
        end
        TX_DATA:   if (bit_end) begin
          sh_d   = {1'b1, sh_q[8:1]};
          tbit_d = tbit_q + 4'h1;
          if (last_bit) begin
            tst_d = TX_STOP;
            shf_d = 1'b0;
          end
        end
        // a load on the very last stop tick must not strand a full shifter in idle
        TX_STOP:   if (bit_end) tst_d = shf_q ? TX_START : (pop ? TX_LOADED : TX_IDLE);
        default:   tst_d = TX_IDLE;
      endcase
      if (pop) begin
        sh_d   = build(mode, ctrl_q[`CTL_ODD], mem_q[rp_q]);
        len9_d = len9(mode);
        shf_d  = 1'b1;
      end
    end
    // line follows the next state so the pin changes with the state
    case (tst_d)
      TX_START: txd_d = 1'b0;
      TX_DATA:  txd_d = sh_d[0];
      default:  txd_d = 1'b1;
    endcase
  end

  // receiver: echo taps the registered pin, already in this domain
  assign rin = ctrl_q[`CTL_ECHO] ? txd_q : s2_q;
  assign rx_keep = (mode != `MODE_WAKE) | rsh_q[8];

  always_comb begin
    rst_d   = rst_q;
    rcnt_d  = rcnt_q;
    rbit_d  = rbit_q;
    rsh_d   = rsh_q;
    rx_done = 1'b0;
    if (run && tick) begin
      rcnt_d = rcnt_q + 4'h1;
      case (rst_q)
        RX_IDLE:  if (!rin) begin
          rst_d  = RX_START;
          rcnt_d = 4'h0;
        end
        RX_START: if (rcnt_q == `OS_MID && rin) begin
          rst_d = RX_IDLE;
        end else if (rcnt_q == `OS_LAST) begin
          rst_d  = RX_DATA;
          rbit_d = 4'h0;
        end
        RX_DATA: begin
          if (rcnt_q == `OS_MID) rsh_d = {rin, rsh_q[8:1]};
          if (rcnt_q == `OS_LAST) begin
            rbit_d = rbit_q + 4'h1;
            if (rbit_q == (len9(mode) ? `BIT_LAST9 : `BIT_LAST8)) rst_d = RX_STOP;
          end
        end
        RX_STOP:  if (rcnt_q == `OS_MID) begin
          rst_d   = RX_IDLE;
          rx_done = 1'b1;
        end
        default:  rst_d = RX_IDLE;
      endcase
    end
    // a new frame wins over a clearing read in the same cycle
    rxf_d = (rxf_q & ~rx_clr) | (rx_done & rx_keep);
    rxb_d = rxb_q;
    if (rx_done && rx_keep) begin
      rxb_d = {~rin, len9(mode) ? rsh_q : {1'b0, rsh_q[8:1]}};
    end
  end

  // all state registers; ce low freezes everything
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q   <= `CTRL_RST;
      baud_q   <= `BAUD_RST;
      div_q    <= 16'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OK;
      rvalid_q <= 1'b0;
      rresp_q  <= `RESP_OK;
      rdata_q  <= 32'h0;
      wp_q     <= '0;
      rp_q     <= '0;
      cnt_q    <= '0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= 9'h0;
      tst_q    <= TX_IDLE;
      tcnt_q   <= 4'h0;
      tbit_q   <= 4'h0;
      sh_q     <= 9'h1ff;
      shf_q    <= 1'b0;
      len9_q   <= 1'b0;
      txd_q    <= 1'b1;
      s1_q     <= 1'b1;
      s2_q     <= 1'b1;
      rst_q    <= RX_IDLE;
      rcnt_q   <= 4'h0;
      rbit_q   <= 4'h0;
      rsh_q    <= 9'h0;
      rxf_q    <= 1'b0;
      rxb_q    <= 10'h0;
    end else if (ce_i) begin
      ctrl_q   <= ctrl_d;
      baud_q   <= baud_d;
      div_q    <= div_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
      wp_q     <= wp_d;
      rp_q     <= rp_d;
      cnt_q    <= cnt_d;
      mem_q    <= mem_d;
      tst_q    <= tst_d;
      tcnt_q   <= tcnt_d;
      tbit_q   <= tbit_d;
      sh_q     <= sh_d;
      shf_q    <= shf_d;
      len9_q   <= len9_d;
      txd_q    <= txd_d;
      s1_q     <= rxd_i;
      s2_q     <= s1_q;
      rst_q    <= rst_d;
      rcnt_q   <= rcnt_d;
      rbit_q   <= rbit_d;
      rsh_q    <= rsh_d;
      rxf_q    <= rxf_d;
      rxb_q    <= rxb_d;
    end
  end

  // checks on the block's own outputs and state
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  drop_when_full_a: assert property (ce_i && push && qen && full && !pop && !flush |=>
    cnt_q == $past(cnt_q)) else $error("write to full queue changed count");
  replace_held_a: assert property (ce_i && push && !qen && full && !pop && !flush |=>
    cnt_q == CW'(1) && mem_q[rp_q] == $past(s_axi_wdata_i[8:0]))
    else $error("held character not replaced");
  half_free_a: assert property (half_free |-> (qen ? cnt_q <= CW'(HALF) : cnt_q == '0))
    else $error("half free flag wrong");
  flush_empty_a: assert property (ce_i && flush |=> cnt_q == '0 && !full)
    else $error("flush did not empty queue");
  idle_load_a: assert property (ce_i && run && tst_q == TX_IDLE && !shf_q && q_ne
    |=> shf_q && tst_q == TX_LOADED) else $error("idle shifter not loaded");
  start_tick_a: assert property (ce_i && run && tst_q == TX_LOADED && tick
    |=> !txd_q && tst_q == TX_START) else $error("start bit not on tick");
  bit_length_a: assert property (ce_i && tst_q == TX_START && tick && tcnt_q == 4'h0
    |=> tst_q == TX_START) else $error("start bit ended early");
  stop_empty_a: assert property (ce_i && stop_begin && !q_ne
    |=> !shf_q && tst_q == TX_STOP && txd_q) else $error("shifter not empty at stop");
  parity_bit_a: assert property (ce_i && pop && mode == `MODE_8P
    |=> sh_q[8] == (^sh_q[7:0] ^ $past(ctrl_q[`CTL_ODD]))) else $error("parity bit wrong");
  wake_drop_a: assert property (ce_i && rx_done && !rx_keep && !rxf_q
    |=> !rxf_q) else $error("wake-up frame without mark kept");
  run_freeze_a: assert property (ce_i && !run && !flush
    |=> $stable(tst_q) && $stable(rst_q) && $stable(tcnt_q)) else $error("state moved while stopped");

  back_to_back_c: cover property (ce_i && stop_begin && q_ne);
  queue_full_c: cover property (qen && full);
  wake_discard_c: cover property (rx_done && !rx_keep);
  echo_frame_c: cover property (ctrl_q[`CTL_ECHO] && rx_done);
endmodule // uart_port

/* File: bench/uart_peer.sv */
// far-end serial device: takes frames from the port and sends frames to it
// assumes an idle-high line and a bit time of bit_cyc clock cycles
`timescale 1ns/1ps
module uart_peer (
  // clock and serial lines
  input  wire logic ref_clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  int  bit_cyc = 16;
  time t_start = 0;
  time t_prev  = 0;

  // the line idles high between frames, as a pulled-up line would
  initial rxd_o = 1'b1;

  // wait for a start bit, then sample each bit near its middle
  task automatic rx_frame(input int nb, output logic [8:0] d, output logic stp);
    d = 9'h000;
    do @(posedge ref_clk_i); while (txd_i !== 1'b0);
    t_prev = t_start;
    t_start = $time;
    repeat (bit_cyc / 2) @(posedge ref_clk_i);
    for (int i = 0; i < nb; i++) begin
      repeat (bit_cyc) @(posedge ref_clk_i);
      d[i] = txd_i;
    end
    repeat (bit_cyc) @(posedge ref_clk_i);
    stp = txd_i;
  endtask

  // start low, bits lsb first, one stop bit; called just after a clock edge
  task automatic tx_frame(input int nb, input logic [8:0] d);
    rxd_o <= 1'b0;
    repeat (bit_cyc) @(posedge ref_clk_i);
    for (int i = 0; i < nb; i++) begin
      rxd_o <= d[i];
      repeat (bit_cyc) @(posedge ref_clk_i);
    end
    rxd_o <= 1'b1;
    repeat (bit_cyc) @(posedge ref_clk_i);
  endtask
endmodule // uart_peer

/* File: bench/uart_frame_and_transmit_path_tb.sv */
// testbench of the serial port: bus tasks, one task per scenario, report
// assumes uart_port and uart_peer; divisor 1 gives 16 clocks a bit
`timescale 1ns/1ps
`include "uart_consts.svh"
module uart_frame_and_transmit_path_tb;
  // bus, line and bookkeeping signals
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        ce      = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, txd, rxd;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          bad_count   = 0;
  int          checks_done = 0;
  int          cyc         = 0;

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  // hang guard: the whole run needs well under 20000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  uart_port u_dut (
    .ref_clk_i(ref_clk), .rst_i(rst), .ce_i(ce),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rxd_i(rxd), .txd_o(txd)
  );

  uart_peer u_peer (.ref_clk_i(ref_clk), .txd_i(txd), .rxd_o(rxd));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask

  // one write; the trailing edge keeps bready from being set twice at one time
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge ref_clk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic setc(input logic [2:0] m, input logic odd, run, qen, echo);
    logic [1:0] r;
    wr(`OFF_CTRL, {25'h0, echo, qen, run, odd, m}, r);
  endtask

  // status bits: full, half free, shifter empty
  task automatic stat(input string nm, input logic [2:0] e);
    logic [31:0] v;
    logic [1:0]  r;
    rd(`OFF_STAT, v, r);
    chk(nm, {29'h0, e}, {29'h0, v[2:0]});
  endtask

  // bits expected on the line after the start bit, parity worked out here
  function automatic logic [8:0] frame_bits(input logic [2:0] m, input logic odd,
                                            input logic [8:0] d);
    case (m)
      `MODE_7P: return {1'b0, (^d[6:0]) ^ odd, d[6:0]};
      `MODE_8P: return {(^d[7:0]) ^ odd, d[7:0]};
      `MODE_8N: return {1'b0, d[7:0]};
      default:  return d;
    endcase
  endfunction

  task automatic t_reset();
    logic [31:0] v;
    logic [1:0]  r;
    // a frozen port refuses a pending read until the enable returns
    ce      <= 1'b0;
    araddr  <= `OFF_CTRL;
    arvalid <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("ready while frozen", 32'h0, {31'h0, arready});
    ce <= 1'b1;
    rd(`OFF_CTRL, v, r);
    chk("ctrl reset", 32'h1, v);
    rd(`OFF_BAUD, v, r);
    chk("baud reset", 32'h1, v);
    stat("status reset", 3'h6);
    rd(8'h18, v, r);
    chk("unmapped read", 32'h2, {30'h0, r});
    wr(8'h1c, 32'hffff_ffff, r);
    chk("unmapped write", 32'h2, {30'h0, r});
    $display("test reset done");
  endtask

  task automatic t_modes();
    logic [17:0] md = {`MODE_WAKE, `MODE_8P, `MODE_9N, `MODE_7P, `MODE_7P, `MODE_8N};
    logic [5:0] od = 6'b010100;
    logic [8:0] d, f;
    logic [1:0] r;
    logic       sb;
    for (int i = 0; i < 6; i++) begin
      d = 9'h1b5 ^ 9'(i);
      setc(md[3*i +: 3], od[i], 1'b1, 1'b1, 1'b0);
      if (i == 0) wr(`OFF_FLUSH, 32'h0, r);
      fork
        u_peer.rx_frame(md[3*i+2] ? 9 : 8, f, sb);
        begin
          wr(`OFF_TXW, {23'h0, d}, r);
          if (i == 0) stat("loaded", 3'h2);
        end
      join
      chk("frame bits", {23'h0, frame_bits(md[3*i +: 3], od[i], d)}, {23'h0, f});
      chk("stop bit", 32'h1, {31'h0, sb});
    end
    $display("test modes done");
  endtask

  task automatic t_queue();
    logic [8:0] f;
    logic [1:0] r;
    logic       sb;
    setc(`MODE_8N, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(`OFF_FLUSH, 32'h0, r);
    for (int i = 0; i < 17; i++) begin
      wr(`OFF_TXW, (i == 16) ? 32'h0ff : 32'(i + 'h40), r);
      if (i == 7) stat("eight held", 3'h6);
      if (i == 8) stat("nine held", 3'h4);
      if (i == 15) stat("sixteen held", 3'h5);
    end
    fork
      setc(`MODE_8N, 1'b0, 1'b1, 1'b1, 1'b0);
      for (int i = 0; i < 16; i++) begin
        u_peer.rx_frame(8, f, sb);
        chk("queued char", 32'(i + 'h40), {23'h0, f});
        if (i > 0) chk("start spacing", 32'd640, 32'(u_peer.t_start - u_peer.t_prev));
      end
    join
    repeat (20) @(posedge ref_clk);
    stat("drained", 3'h6);
    $display("test queue done");
  endtask

  task automatic t_single();
    logic [8:0] f;
    logic [1:0] r;
    logic       sb;
    setc(`MODE_8N, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(`OFF_FLUSH, 32'h0, r);
    wr(`OFF_TXW, 32'h33, r);
    stat("one held", 3'h5);
    wr(`OFF_TXW, 32'hc6, r);
    fork
      setc(`MODE_8N, 1'b0, 1'b1, 1'b0, 1'b0);
      u_peer.rx_frame(8, f, sb);
    join
    chk("replaced char", 32'hc6, {23'h0, f});
    repeat (20) @(posedge ref_clk);
    stat("single drained", 3'h6);
    $display("test single done");
  endtask

  task automatic t_flush();
    logic [1:0] r;
    logic       lo = 1'b0;
    setc(`MODE_8N, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(`OFF_FLUSH, 32'h0, r);
    wr(`OFF_TXW, 32'h55, r);
    wr(`OFF_TXW, 32'haa, r);
    wr(`OFF_FLUSH, 32'h0, r);
    stat("flushed", 3'h6);
    setc(`MODE_8N, 1'b0, 1'b1, 1'b1, 1'b0);
    repeat (200) begin
      @(posedge ref_clk);
      if (txd !== 1'b1) lo = 1'b1;
    end
    chk("line idle", 32'h0, {31'h0, lo});
    $display("test flush done");
  endtask

  task automatic t_echo();
    logic [31:0] v;
    logic [8:0]  f;
    logic [1:0]  r;
    logic        sb;
    setc(`MODE_WAKE, 1'b0, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 2; i++) begin
      fork
        wr(`OFF_TXW, i ? 32'h15a : 32'h0a5, r);
        u_peer.rx_frame(9, f, sb);
      join
      repeat (20) @(posedge ref_clk);
      rd(`OFF_STAT, v, r);
      chk("rx valid", 32'(i), {31'h0, v[3]});
    end
    rd(`OFF_RXD, v, r);
    chk("echoed char", 32'h15a, {22'h0, v[9:0]});
    $display("test echo done");
  endtask

  task automatic t_duplex();
    logic [31:0] v;
    logic [8:0]  f;
    logic [1:0]  r;
    logic        sb;
    wr(`OFF_BAUD, 32'h2, r);
    setc(`MODE_9N, 1'b0, 1'b1, 1'b1, 1'b0);
    u_peer.bit_cyc = 32;
    fork
      wr(`OFF_TXW, 32'h1c3, r);
      u_peer.rx_frame(9, f, sb);
      u_peer.tx_frame(9, 9'h12d);
    join
    repeat (40) @(posedge ref_clk);
    chk("slow frame out", 32'h1c3, {23'h0, f});
    rd(`OFF_RXD, v, r);
    chk("frame in", 32'h12d, {22'h0, v[9:0]});
    $display("test duplex done");
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_modes();
    t_queue();
    t_single();
    t_flush();
    t_echo();
    t_duplex();
    stop_test();
  end
endmodule // uart_frame_and_transmit_path_tb
